// *** design/ldc_map.svh ***
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH

// ****************************************
// Serial slave address and register indices
// ****************************************
`define LDC_SLV_ADDR     7'h08
`define LDC_IDX_BIAS     8'h01
`define LDC_IDX_RSVD     8'h02
`define LDC_IDX_CONV     8'h03
`define LDC_IDX_TXP      8'h0A
`define LDC_IDX_TXS      8'h0B
`define LDC_IDX_RES_HI   8'h28
`define LDC_IDX_RES_LO   8'h29
`define LDC_RST_VAL      8'h00

// ****************************************
// Field positions
// ****************************************
`define LDC_B_PD_ARM     7
`define LDC_B_PD_RNG_HI  6
`define LDC_B_PD_RNG_LO  5
`define LDC_B_OPEN_LOOP  4
`define LDC_B_FLT_ON     3
`define LDC_B_BIAS_ON    2
`define LDC_B_BIAS_SINK  1
`define LDC_B_PD_CATH    0
`define LDC_B_CONV_ON    7
`define LDC_B_CONV_OSC   6
`define LDC_B_CONV_RST   4
`define LDC_B_CONV_SEL   2
`define LDC_B_TX_PD      7
`define LDC_B_DRV_OFF    6
`define LDC_B_INVERT     5
`define LDC_B_REC_OFF    4
`define LDC_B_REC_BYP    3
`define LDC_B_OC_OFF     2
`define LDC_B_EQ_OFF     1
`define LDC_B_ANA_AMP    0
`define LDC_B_HALF_AMP   7
`define LDC_B_WIDE_PK    6
`define LDC_B_TCOMP_HI   5
`define LDC_B_TCOMP_LO   4
`define LDC_B_CTLE_HI    3

// ****************************************
// Photodiode full scale in microamps
// ****************************************
`define LDC_PD_FS_LOW    12'h302
`define LDC_PD_FS_MID    12'h604
`define LDC_PD_FS_HIGH   12'hC08

`endif

// *** design/ldc_pkg.sv ***
package ldc_pkg;

   typedef enum logic [9:0] {
      LDC_IDLE = 10'h001,
      LDC_ADDR = 10'h002,
      LDC_AADR = 10'h004,
      LDC_REG  = 10'h008,
      LDC_AREG = 10'h010,
      LDC_WDAT = 10'h020,
      LDC_AWR  = 10'h040,
      LDC_RDAT = 10'h080,
      LDC_ARD  = 10'h100,
      LDC_SKIP = 10'h200
   } ldc_state_t;

   typedef logic [2:0] ldc_slot_t;

endpackage

// *** design/ldc_regs.sv ***
`timescale 1ns/10ps
`include "ldc_map.svh"

// How it works
// - Arm bit lets monitor pin raise fault
// - Range field sets photodiode full scale
// - Open-loop bias when set, APC when clear
// - Fault detection on when set
// - Bias enable; low-then-high clears latched fault
// - Bias pin sinks when set, sources clear
// - Photodiode cathode-to-supply when set
// - Converter powered when set
// - Converter oscillator runs when set
// - Converter held in reset while set
// - Input select routes four monitors, 1XX none
// - Whole transmit path powered down when set
// - Output driver off when set
// - Data polarity inverted when set
// - Recovery disabled and bypassed when set
// - Data routed around recovery when set
// - Offset cancellation off when set
// - Equalizer disabled and bypassed when set
// - Analog amplitude control when set
// - Amplitude limited to half range
// - Wide peaking when set, narrow clear
// - Equalizer level monotonic 0000 to 1111
// - Slave 0001000; address, index, one data
// - Result high bits at 40, low at 41
module ldc_regs
   import ldc_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        pd_monitor_pin_i,
   input  wire logic        bias_fault_i,
   input  wire logic [9:0]  converter_result_i,
   output logic             pd_monitor_fault_arm_o,
   output logic [1:0]       pd_range_sel_o,
   output logic [11:0]      pd_full_scale_ua_o,
   output logic             open_loop_sel_o,
   output logic             fault_detect_on_o,
   output logic             laser_bias_on_o,
   output logic             bias_current_en_o,
   output logic             fault_latched_o,
   output logic             bias_sink_sel_o,
   output logic             pd_cathode_sel_o,
   output logic             converter_on_o,
   output logic             converter_osc_on_o,
   output logic             converter_hold_reset_o,
   output logic [2:0]       converter_input_sel_o,
   output logic [3:0]       converter_route_o,
   output logic             transmit_powerdown_o,
   output logic             driver_on_o,
   output logic             data_invert_o,
   output logic             recovery_off_o,
   output logic             recovery_bypass_o,
   output logic             recovery_route_around_o,
   output logic             offset_cancel_off_o,
   output logic             equalizer_off_o,
   output logic             analog_amplitude_sel_o,
   output logic             half_amplitude_sel_o,
   output logic             wide_peaking_sel_o,
   output logic [1:0]       output_tempcomp_sel_o,
   output logic [3:0]       input_eq_level_o
);

   // ****************************************
   // Declarations
   // ****************************************
   localparam ldc_slot_t SLOT_NONE = 3'h5;

   logic [3:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        pd_s;
   logic        flt_s;
   logic        scl_q_ff;
   logic        sda_q_ff;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   ldc_state_t  state_ff;
   logic [3:0]  cnt_ff;
   logic [7:0]  shift_ff;
   logic [7:0]  idx_ff;
   logic        rw_ff;
   logic        sda_low_ff;
   logic        wr_stb_ff;
   ldc_slot_t   wr_slot_ff;
   logic [7:0]  wr_data_ff;
   logic [7:0]  regs_ff [0:4];
   logic [9:0]  res_ff;
   logic [7:0]  rd_byte;
   logic [7:0]  bias_r;
   logic [7:0]  conv_r;
   logic [7:0]  txp_r;
   logic [7:0]  txs_r;
   logic        fault_ff;
   logic        bias_on_q_ff;
   logic        fault_src;
   logic        bias_rise;

   function automatic ldc_slot_t slot_of(input logic [7:0] idx);
      case (idx)
         `LDC_IDX_BIAS: slot_of = 3'h0;
         `LDC_IDX_RSVD: slot_of = 3'h1;
         `LDC_IDX_CONV: slot_of = 3'h2;
         `LDC_IDX_TXP:  slot_of = 3'h3;
         `LDC_IDX_TXS:  slot_of = 3'h4;
         default:       slot_of = SLOT_NONE;
      endcase
   endfunction

   // ****************************************
   // Pin synchronisers and bus events
   // ****************************************
   ldc_sync u_sync
   (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   ({bias_fault_i, pd_monitor_pin_i, sda_i, scl_i}),
      .sync_o    (pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign pd_s  = pins_s[2];
   assign flt_s = pins_s[3];

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_q_ff;
   assign scl_fall  = ~scl_s & scl_q_ff;
   assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

   // ****************************************
   // Serial slave: address, index, one data byte
   // ****************************************
   // Extra bytes after the data byte are not acknowledged, so the
   // master sees the one-byte limit as a NACK.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_ff   <= LDC_IDLE;
         cnt_ff     <= 4'h0;
         shift_ff   <= 8'h00;
         idx_ff     <= 8'h00;
         rw_ff      <= 1'b0;
         sda_low_ff <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_slot_ff <= SLOT_NONE;
         wr_data_ff <= 8'h00;
      end
      else
      begin
         wr_stb_ff <= 1'b0;
         if (bus_start)
         begin
            state_ff   <= LDC_ADDR;
            cnt_ff     <= 4'h0;
            sda_low_ff <= 1'b0;
         end
         else if (bus_stop)
         begin
            state_ff   <= LDC_IDLE;
            sda_low_ff <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (state_ff == LDC_ADDR || state_ff == LDC_REG ||
                state_ff == LDC_WDAT)
            begin
               shift_ff <= {shift_ff[6:0], sda_s};
               cnt_ff   <= cnt_ff + 4'h1;
            end
            else if (state_ff == LDC_RDAT)
            begin
               cnt_ff <= cnt_ff + 4'h1;
            end
         end
         else if (scl_fall)
         begin
            case (state_ff)
               LDC_ADDR:
               begin
                  if (cnt_ff == 4'h8)
                  begin
                     if (shift_ff[7:1] == `LDC_SLV_ADDR)
                     begin
                        state_ff   <= LDC_AADR;
                        rw_ff      <= shift_ff[0];
                        sda_low_ff <= 1'b1;
                     end
                     else
                     begin
                        state_ff <= LDC_SKIP;
                     end
                  end
               end
               LDC_AADR:
               begin
                  state_ff   <= LDC_REG;
                  cnt_ff     <= 4'h0;
                  sda_low_ff <= 1'b0;
               end
               LDC_REG:
               begin
                  if (cnt_ff == 4'h8)
                  begin
                     state_ff   <= LDC_AREG;
                     idx_ff     <= shift_ff;
                     sda_low_ff <= 1'b1;
                  end
               end
               LDC_AREG:
               begin
                  cnt_ff <= 4'h0;
                  if (rw_ff)
                  begin
                     state_ff   <= LDC_RDAT;
                     shift_ff   <= rd_byte;
                     sda_low_ff <= ~rd_byte[7];
                  end
                  else
                  begin
                     state_ff   <= LDC_WDAT;
                     sda_low_ff <= 1'b0;
                  end
               end
               LDC_WDAT:
               begin
                  if (cnt_ff == 4'h8)
                  begin
                     state_ff   <= LDC_AWR;
                     sda_low_ff <= 1'b1;
                     wr_stb_ff  <= 1'b1;
                     wr_slot_ff <= slot_of(idx_ff);
                     wr_data_ff <= shift_ff;
                  end
               end
               LDC_RDAT:
               begin
                  if (cnt_ff == 4'h8)
                  begin
                     state_ff   <= LDC_ARD;
                     sda_low_ff <= 1'b0;
                  end
                  else
                  begin
                     shift_ff   <= {shift_ff[6:0], 1'b0};
                     sda_low_ff <= ~shift_ff[6];
                  end
               end
               LDC_AWR, LDC_ARD:
               begin
                  state_ff   <= LDC_SKIP;
                  sda_low_ff <= 1'b0;
               end
               LDC_IDLE, LDC_SKIP:
               begin
                  sda_low_ff <= 1'b0;
               end
               default:
               begin
                  state_ff   <= LDC_IDLE;
                  sda_low_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain: the pin only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_low_ff;

   // ****************************************
   // Register storage
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 5; g++)
      begin : slot
         always_ff @(posedge ref_clk_i)
         begin
            if (rst_i)
            begin
               regs_ff[g] <= `LDC_RST_VAL;
            end
            else if (wr_stb_ff && wr_slot_ff == 3'(g))
            begin
               regs_ff[g] <= wr_data_ff;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         res_ff <= 10'h000;
      end
      else
      begin
         res_ff <= converter_result_i;
      end
   end

   assign bias_r = regs_ff[0];
   assign conv_r = regs_ff[2];
   assign txp_r  = regs_ff[3];
   assign txs_r  = regs_ff[4];

   // Unmapped indices read as zero
   always_comb
   begin
      rd_byte = 8'h00;
      if (slot_of(idx_ff) != SLOT_NONE)
      begin
         rd_byte = regs_ff[slot_of(idx_ff)];
      end
      else if (idx_ff == `LDC_IDX_RES_HI)
      begin
         rd_byte = res_ff[9:2];
      end
      else if (idx_ff == `LDC_IDX_RES_LO)
      begin
         rd_byte = {6'h00, res_ff[1:0]};
      end
   end

   // ****************************************
   // Fault latch
   // ****************************************
   assign fault_src = bias_r[`LDC_B_FLT_ON] &
                      (flt_s | (bias_r[`LDC_B_PD_ARM] & pd_s));
   assign bias_rise = bias_r[`LDC_B_BIAS_ON] & ~bias_on_q_ff;

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         bias_on_q_ff <= 1'b0;
      end
      else
      begin
         bias_on_q_ff <= bias_r[`LDC_B_BIAS_ON];
      end
   end

   // A fresh fault in the clearing cycle wins over the clear
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         fault_ff <= 1'b0;
      end
      else if (fault_src)
      begin
         fault_ff <= 1'b1;
      end
      else if (bias_rise)
      begin
         fault_ff <= 1'b0;
      end
   end

   // ****************************************
   // Control outputs
   // ****************************************
   assign pd_monitor_fault_arm_o = bias_r[`LDC_B_PD_ARM];
   assign pd_range_sel_o  = bias_r[`LDC_B_PD_RNG_HI:`LDC_B_PD_RNG_LO];
   assign open_loop_sel_o   = bias_r[`LDC_B_OPEN_LOOP];
   assign fault_detect_on_o = bias_r[`LDC_B_FLT_ON];
   assign laser_bias_on_o   = bias_r[`LDC_B_BIAS_ON];
   assign bias_current_en_o = bias_r[`LDC_B_BIAS_ON] & ~fault_ff;
   assign fault_latched_o   = fault_ff;
   assign bias_sink_sel_o   = bias_r[`LDC_B_BIAS_SINK];
   assign pd_cathode_sel_o  = bias_r[`LDC_B_PD_CATH];

   always_comb
   begin
      if (pd_range_sel_o[1])
      begin
         pd_full_scale_ua_o = `LDC_PD_FS_HIGH;
      end
      else if (pd_range_sel_o[0])
      begin
         pd_full_scale_ua_o = `LDC_PD_FS_MID;
      end
      else
      begin
         pd_full_scale_ua_o = `LDC_PD_FS_LOW;
      end
   end

   assign converter_on_o         = conv_r[`LDC_B_CONV_ON];
   assign converter_osc_on_o     = conv_r[`LDC_B_CONV_OSC];
   assign converter_hold_reset_o = conv_r[`LDC_B_CONV_RST];
   assign converter_input_sel_o  = conv_r[`LDC_B_CONV_SEL:0];

   // Reserved select codes route nothing
   always_comb
   begin
      converter_route_o = 4'h0;
      if (!converter_input_sel_o[2])
      begin
         converter_route_o[converter_input_sel_o[1:0]] = 1'b1;
      end
   end

   assign transmit_powerdown_o    = txp_r[`LDC_B_TX_PD];
   assign driver_on_o             = ~txp_r[`LDC_B_TX_PD] &
                                    ~txp_r[`LDC_B_DRV_OFF];
   assign data_invert_o           = txp_r[`LDC_B_INVERT];
   assign recovery_off_o          = txp_r[`LDC_B_REC_OFF];
   assign recovery_bypass_o       = txp_r[`LDC_B_REC_BYP];
   assign recovery_route_around_o = txp_r[`LDC_B_REC_OFF] |
                                    txp_r[`LDC_B_REC_BYP];
   assign offset_cancel_off_o     = txp_r[`LDC_B_OC_OFF];
   assign equalizer_off_o         = txp_r[`LDC_B_EQ_OFF];
   assign analog_amplitude_sel_o  = txp_r[`LDC_B_ANA_AMP];
   assign half_amplitude_sel_o    = txs_r[`LDC_B_HALF_AMP];
   assign wide_peaking_sel_o      = txs_r[`LDC_B_WIDE_PK];
   assign output_tempcomp_sel_o   = txs_r[`LDC_B_TCOMP_HI:`LDC_B_TCOMP_LO];
   assign input_eq_level_o        = txs_r[`LDC_B_CTLE_HI:0];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   fault_arm_a: assert property (
      fault_detect_on_o && pd_monitor_fault_arm_o && pd_s |=> fault_latched_o)
      else $error("armed monitor pin did not latch a fault");

   fault_off_a: assert property (
      !fault_detect_on_o && !fault_latched_o |=> !fault_latched_o)
      else $error("fault latched while detection off");

   fault_clear_a: assert property (
      !laser_bias_on_o ##1 laser_bias_on_o && !fault_src |=> !fault_latched_o)
      else $error("bias re-enable did not clear fault");

   bias_gate_a: assert property (
      fault_latched_o |-> !bias_current_en_o)
      else $error("bias current on during fault");

   pd_range_a: assert property (
      pd_range_sel_o == 2'h1 |-> pd_full_scale_ua_o == 12'h604)
      else $error("photodiode range mid scale wrong");

   conv_route_a: assert property (
      $onehot0(converter_route_o) and
      (converter_input_sel_o[2] |-> converter_route_o == 4'h0))
      else $error("converter route not one-hot");

   tx_down_a: assert property (
      transmit_powerdown_o |-> !driver_on_o)
      else $error("driver on during powerdown");

   reg_write_a: assert property (
      wr_stb_ff && wr_slot_ff == 3'h3 |=> txp_r == $past(wr_data_ff))
      else $error("transmit register write lost");

   rsvd_keep_a: assert property (
      wr_stb_ff && wr_slot_ff == 3'h1 ##1 !wr_stb_ff [*3]
      |-> regs_ff[1] == $past(wr_data_ff, 3))
      else $error("reserved register did not hold value");

   addr_ack_a: assert property (
      state_ff == LDC_AADR |-> sda_oe_o)
      else $error("address not acknowledged");

   ack_release_a: assert property (
      state_ff == LDC_SKIP && $past(state_ff) == LDC_SKIP |-> !sda_oe_o)
      else $error("data line held after transfer");

   write_cov: cover property (wr_stb_ff);
   read_cov: cover property (state_ff == LDC_RDAT ##[1:1000] state_ff == LDC_ARD);
   clear_cov: cover property (fault_latched_o ##[1:1000] !fault_latched_o);

endmodule

// *** design/ldc_sync.sv ***
`timescale 1ns/10ps

// ****************************************
// Two-stage synchroniser, one lane per bit
// ****************************************
module ldc_sync
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic [3:0] async_i,
   output logic      [3:0] sync_o
);

   logic [3:0] meta_ff;
   logic [3:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : lane
         always_ff @(posedge ref_clk_i)
         begin
            if (rst_i)
            begin
               meta_ff[g] <= 1'b1;
               sync_ff[g] <= 1'b1;
            end
            else
            begin
               meta_ff[g] <= async_i[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;

endmodule

// *** tb/ldc_host.sv ***
`timescale 1ns/10ps

// ****************************************
// Host serial master, open drain on the data line, clock driven both ways
// ****************************************
module ldc_host
(
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // Ten clocks a phase, far above the sync latency
   task automatic bit_io(input logic b, output logic s);
      sda_low_o <= ~b;
      wt(10);
      scl_o <= 1'b1;
      wt(10);
      s = sda_i;
      scl_o <= 1'b0;
      wt(3); // Hold data past the clock fall, else seen as start or stop
   endtask

   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(1'b1, s); // Released: a read always ends in a host NACK
      ack = ~s;
   endtask

   task automatic xfer(input logic [6:0] sa, input logic rnw, input logic [7:0] idx,
                       input logic [7:0] wd, input logic extra,
                       output logic [7:0] rd, output logic [3:0] ak);
      logic [7:0] x;
      ak[0] = 1'b0;
      sda_low_o <= 1'b1; // Start
      wt(10);
      scl_o <= 1'b0;
      wt(3);
      byte_io({sa, rnw}, x, ak[3]);
      byte_io(idx, x, ak[2]);
      byte_io(rnw ? 8'hFF : wd, rd, ak[1]);
      if (extra)
         byte_io(8'h3C, x, ak[0]);
      sda_low_o <= 1'b1;
      wt(10);
      scl_o <= 1'b1;
      wt(10);
      sda_low_o <= 1'b0; // Stop
      wt(10);
   endtask
endmodule

// *** tb/ldc_regs_tb.sv ***
`timescale 1ns/10ps
`include "ldc_map.svh"

module ldc_regs_tb;
   logic        ref_clk_i;
   logic        rst_i;
   logic        pd_pin, bfault, scl, sda_low, so, soe;
   logic [9:0]  res;
   logic        arm, opn, fdo, bon, ben, flt, snk, cth, con, osc, hrs;
   logic        tpd, drv, inv, rof, rby, rar, ocf, eqf, ana, hlf, wpk;
   logic [1:0]  rng, tcs;
   logic [2:0]  sel;
   logic [3:0]  rte, eql, ak;
   logic [11:0] fs;
   logic [7:0]  d;
   logic [7:0]  sh [0:255];
   int          errors = 0;
   int          n_tests = 0;
   logic [15:0] rows [16] = '{16'h01A5, 16'h015A, 16'h0160, 16'h02C3, 16'h03F8, 16'h0301,
                              16'h0342, 16'h0393, 16'h0304, 16'h0307, 16'h0AAA, 16'h0A55,
                              16'h0A18, 16'h0BA5, 16'h0B5F, 16'h0BF0};
   // Pull-up on the data line
   wire         sda = (sda_low || (soe && !so)) ? 1'b0 : 1'b1;

   initial
   begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   ldc_host host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   ldc_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(so),
      .sda_oe_o(soe), .pd_monitor_pin_i(pd_pin), .bias_fault_i(bfault),
      .converter_result_i(res), .pd_monitor_fault_arm_o(arm), .pd_range_sel_o(rng),
      .pd_full_scale_ua_o(fs), .open_loop_sel_o(opn), .fault_detect_on_o(fdo),
      .laser_bias_on_o(bon), .bias_current_en_o(ben), .fault_latched_o(flt),
      .bias_sink_sel_o(snk), .pd_cathode_sel_o(cth), .converter_on_o(con),
      .converter_osc_on_o(osc), .converter_hold_reset_o(hrs), .converter_input_sel_o(sel),
      .converter_route_o(rte), .transmit_powerdown_o(tpd), .driver_on_o(drv),
      .data_invert_o(inv), .recovery_off_o(rof), .recovery_bypass_o(rby),
      .recovery_route_around_o(rar), .offset_cancel_off_o(ocf), .equalizer_off_o(eqf),
      .analog_amplitude_sel_o(ana), .half_amplitude_sel_o(hlf), .wide_peaking_sel_o(wpk),
      .output_tempcomp_sel_o(tcs), .input_eq_level_o(eql));

   // ****************************************
   // Checks and bus helpers
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic chk_all;
      logic [7:0] r1, r3, ra;
      r1 = sh[1];
      r3 = sh[3];
      ra = sh[10];
      chk("reg1", {arm, rng, opn, fdo, bon, snk, cth}, r1);
      chk("scale", fs, r1[6] ? 12'hC08 : (r1[5] ? 12'h604 : 12'h302));
      chk("reg3", {con, osc, hrs, sel}, {r3[7:6], r3[4], r3[2:0]});
      chk("route", rte, r3[2] ? 4'h0 : 4'h1 << r3[1:0]);
      chk("reg10", {tpd, inv, rof, rby, ocf, eqf, ana}, {ra[7], ra[5:0]});
      chk("drv", {drv, rar}, {~ra[7] & ~ra[6], ra[4] | ra[3]});
      chk("reg11", {hlf, wpk, tcs, eql}, sh[11]);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] dv);
      host.xfer(`LDC_SLV_ADDR, 1'b0, idx, dv, 1'b0, d, ak);
      chk("write acks", ak[3:1], 3'h7);
      if (idx inside {8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B})
         sh[idx] = dv;
   endtask

   task automatic rd(input logic [7:0] idx);
      host.xfer(`LDC_SLV_ADDR, 1'b1, idx, 8'hFF, 1'b0, d, ak);
      chk("read acks", ak[3:2], 2'h3);
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge ref_clk_i);
      errors++;
      tally_and_finish;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rst_i  = 1'b1;
      pd_pin = 1'b0;
      bfault = 1'b0;
      res    = 10'h000;
      foreach (sh[i]) sh[i] = 8'h00;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk_all;
      for (int i = 0; i < 16; i++)
      begin
         wr(rows[i][15:8], rows[i][7:0]);
         chk_all;
         rd(rows[i][15:8]);
         chk("readback", d, sh[rows[i][15:8]]);
         $display("Row %0d done", i);
      end
      host.xfer(7'h09, 1'b0, 8'h01, 8'hFF, 1'b0, d, ak);
      chk("foreign address", ak[3], 1'b0);
      host.xfer(`LDC_SLV_ADDR, 1'b0, 8'h0B, 8'h3C, 1'b1, d, ak);
      chk("extra byte", ak, 4'hE);
      sh[11] = 8'h3C;
      chk_all;
      wr(8'h05, 8'h77);
      rd(8'h05);
      chk("unmapped", d, 8'h00);
      chk_all;
      $display("Bus refusals done");
      res <= 10'h2B6;
      rd(8'h28);
      chk("result high", d, 8'hAD);
      rd(8'h29);
      chk("result low", d, 8'h02);
      $display("Result read done");
      wr(8'h01, 8'h8C);
      pd_pin <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk("fault set", {flt, ben}, 2'b10);
      pd_pin <= 1'b0;
      wr(8'h01, 8'h88);
      wr(8'h01, 8'h8C);
      chk("fault clear", {flt, ben}, 2'b01);
      wr(8'h01, 8'h0C);
      pd_pin <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk("arm off", {flt, ben}, 2'b01);
      wr(8'h01, 8'h04);
      bfault <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk("detect off", {flt, ben}, 2'b01);
      pd_pin <= 1'b0;
      wr(8'h01, 8'h0C);
      repeat (8) @(posedge ref_clk_i);
      chk("source fault", {flt, ben}, 2'b10);
      bfault <= 1'b0;
      $display("Fault done");
      rst_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (sh[i]) sh[i] = 8'h00;
      repeat (4) @(posedge ref_clk_i);
      chk_all;
      chk("reset fault", {flt, ben}, 2'b00);
      rd(8'h0A);
      chk("reset read", d, 8'h00);
      $display("Mid reset done");
      tally_and_finish;
   end
endmodule
